// *** dhi_map.svh ***
// Register offsets, field positions, reset values and timing counts of the converter host.
// Behaviour
// [RL1] Load strobe sits at its own register word.
// [RL2] Load strobe never shares the select timing.
// [RL3] Held-low strobe: write rising edge updates output.
// [RL4] Serial mode leaves parallel bus idle.
// [RL5] Held-low strobe: sixteenth falling clock updates.
// [RL6] Serial data stable at each falling clock.
// [RL7] Data changes after falling edge, never inverted.
// [RL8] Frame marker driven active low directly.
// [RL9] Sixteen-bit words, gated clock, frame driven.
// [RL10] Order high, alignment low: most significant first.
// [RL11] Order low, alignment high: least significant first.
// [RL12] Load strobe timed by the same sequencer.
// [RL13] Companion gating: start only while strobe low.
// [RL14] Two padding bits lead, then fourteen data.
// [RL15] Fourteen data bits lead, two padding trail.
// [RL16] No load strobe while a frame runs.
// [RL17] Parallel word held on bus across write.
// [RL18] Separate load pulse after transfer completes.
`ifndef DHI_MAP_SVH
`define DHI_MAP_SVH

`define DHI_OFF_CTRL 12'h000
`define DHI_OFF_DIV 12'h004
`define DHI_OFF_DATA 12'h008
`define DHI_OFF_LOAD 12'h00c
`define DHI_OFF_STATUS 12'h010

`define DHI_CTRL_SERIAL 0
`define DHI_CTRL_ORDER 1
`define DHI_CTRL_ALIGN 2
`define DHI_CTRL_HELD_LOW 3
`define DHI_CTRL_LOAD_AFTER 4
`define DHI_CTRL_GATE 5

`define DHI_STAT_OVERRUN 0
`define DHI_STAT_BUSY 1
`define DHI_STAT_COMPANION 2

`define DHI_CTRL_RESET 6'h00
`define DHI_DIV_RESET 8'h09

`define DHI_CLK_NS 10
`define DHI_SETUP_NS 21
`define DHI_WR_NS 45
`define DHI_LOAD_NS 45
`define DHI_CYC(ns) (((ns) + `DHI_CLK_NS - 1) / `DHI_CLK_NS)
`define DHI_SETUP_CYC `DHI_CYC(`DHI_SETUP_NS)
`define DHI_WR_CYC `DHI_CYC(`DHI_WR_NS)
`define DHI_LOAD_CYC `DHI_CYC(`DHI_LOAD_NS)

`endif

// *** dhi_pkg.sv ***
// Types shared by the converter host modules.
package dhi_pkg;

	typedef enum logic [2:0] {
		dhi_idle,
		dhi_setup,
		dhi_strobe,
		dhi_hold,
		dhi_gate,
		dhi_shift,
		dhi_load
	} dhi_seq_type;

	typedef struct packed {
		dhi_seq_type state;
		logic [5:0] ctrl;
		logic [7:0] half_div;
		logic [13:0] word;
		logic [3:0] cnt;
		logic overrun;
		logic cs_n;
		logic [13:0] bus;
		logic load_n;
		logic [2:0] sync;
		logic comp_level;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} dhi_host_type;

	typedef struct packed {
		logic active;
		logic tail;
		logic sclk;
		logic sync_n;
		logic sdata;
		logic done;
		logic [3:0] bits;
		logic [7:0] cnt;
		logic [15:0] shreg;
	} dhi_ser_type;

endpackage

// *** dhi_pulse.sv ***
// Low-going strobe of a fixed number of clock cycles.
`timescale 1ns/10ps
`default_nettype none
module dhi_pulse
	import dhi_pkg::*;
#(
	parameter int CYCLES = 5
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Request and result.
	input wire logic start,
	output logic pulse_n,
	output logic done
);

	localparam int CW = $clog2(CYCLES + 1);

	typedef struct packed {
		logic active;
		logic pulse_n;
		logic done;
		logic [CW-1:0] cnt;
	} dhi_pulse_type;

	dhi_pulse_type cur, next;

	// ==========================================================
	// Sequencing.
	always_comb begin
		next = cur;
		next.done = 1'b0;
		if (!cur.active) begin
			if (start) begin
				next.active = 1'b1;
				next.pulse_n = 1'b0;
				next.cnt = CW'(CYCLES - 1);
			end
		end else if (cur.cnt != '0) begin
			next.cnt = cur.cnt - 1'b1;
		end else begin
			next.active = 1'b0;
			next.pulse_n = 1'b1;
			next.done = 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cur <= '{active: 1'b0, pulse_n: 1'b1, done: 1'b0, cnt: '0};
		end else begin
			cur <= next;
		end
	end

	assign pulse_n = cur.pulse_n;
	assign done = cur.done;

endmodule // dhi_pulse
`default_nettype wire

// *** dhi_serial_tx.sv ***
// Sixteen-bit serial frame sender with gated bit clock and active-low frame marker.
`timescale 1ns/10ps
`default_nettype none
module dhi_serial_tx
	import dhi_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Request.
	input wire logic start,
	input wire logic [15:0] frame,
	input wire logic [7:0] half_div,
	// Link pins.
	output logic sclk,
	output logic sync_n,
	output logic sdata,
	// Result.
	output logic done
);

	dhi_ser_type cur, next;

	// ==========================================================
	// Bit sequencing.
	always_comb begin
		next = cur;
		next.done = 1'b0;
		if (!cur.active) begin
			// [RL9] Frame and clock start.
			if (start) begin
				next.active = 1'b1;
				next.sync_n = 1'b0;
				next.sdata = frame[15];
				next.shreg = {frame[14:0], 1'b0};
				next.bits = 4'h0;
				next.cnt = half_div;
			end
		end else if (cur.cnt > 8'h01) begin
			next.cnt = cur.cnt - 8'h01;
			// [RL7] Change after fall.
			// Moving the bit one clock after the fall keeps hold time at the converter's sampling edge.
			if (!cur.sclk && cur.cnt == half_div && cur.bits != 4'h0 && !cur.tail) begin
				next.sdata = cur.shreg[15];
				next.shreg = {cur.shreg[14:0], 1'b0};
			end
		end else begin
			next.cnt = half_div;
			if (cur.tail) begin
				// [RL8] Frame marker release.
				next.sync_n = 1'b1;
				next.active = 1'b0;
				next.tail = 1'b0;
				next.done = 1'b1;
			end else if (!cur.sclk) begin
				next.sclk = 1'b1;
			end else begin
				// [RL6] Falling edge samples.
				next.sclk = 1'b0;
				if (cur.bits == 4'hf) begin
					next.tail = 1'b1;
				end else begin
					next.bits = cur.bits + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cur <= '{active: 1'b0, tail: 1'b0, sclk: 1'b0, sync_n: 1'b1, sdata: 1'b0,
				done: 1'b0, bits: 4'h0, cnt: 8'h00, shreg: 16'h0000};
		end else begin
			cur <= next;
		end
	end

	assign sclk = cur.sclk;
	assign sync_n = cur.sync_n;
	assign sdata = cur.sdata;
	assign done = cur.done;

endmodule // dhi_serial_tx
`default_nettype wire

// *** dhi_dac_host.sv ***
// Host controller that loads a dual-latch converter over its parallel or serial pins.
`timescale 1ns/10ps
`default_nettype none
`include "dhi_map.svh"
module dhi_dac_host
	import dhi_pkg::*;
#(
	parameter int SETUP_CYCLES = `DHI_SETUP_CYC,
	parameter int WR_CYCLES = `DHI_WR_CYC,
	parameter int LOAD_CYCLES = `DHI_LOAD_CYC
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Register bus.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Parallel pins.
	output logic dac_cs_n,
	output logic dac_wr_n,
	output logic [13:0] dac_data,
	output logic output_load_strobe_n,
	// Serial pins.
	output logic dac_sclk,
	output logic dac_sync_n,
	output logic dac_sdata,
	// Straps and mode level.
	output logic serial_mode_select,
	output logic bit_order_select,
	output logic alignment_select,
	// Companion converter.
	input wire logic companion_frame_strobe
);

	dhi_host_type cur, next;

	logic access;
	logic wr_go;
	logic wr_done;
	logic wr_pulse_n;
	logic load_go;
	logic load_done;
	logic load_pulse_n;
	logic ser_go;
	logic ser_done;
	logic [13:0] word_rev;
	logic [13:0] word_ord;
	logic [15:0] frame;

	// ==========================================================
	// Frame layout.
	genvar gi;
	generate
		for (gi = 0; gi < 14; gi++) begin : g_rev
			assign word_rev[gi] = cur.word[13 - gi];
		end
	endgenerate

	// [RL10] Order select picks most significant first.
	// [RL11] Order low sends least significant first.
	assign word_ord = cur.ctrl[`DHI_CTRL_ORDER] ? cur.word : word_rev;

	// [RL14] Padding ahead of the data.
	// [RL15] Padding after the data.
	assign frame = cur.ctrl[`DHI_CTRL_ALIGN] ? {word_ord, 2'b00} : {2'b00, word_ord};

	// ==========================================================
	// Register bus and sequencer.
	always_comb begin
		next = cur;
		wr_go = 1'b0;
		load_go = 1'b0;
		ser_go = 1'b0;
		access = psel & penable & cur.pready;

		// The companion strobe is a foreign level; one flop alone would let glitches through.
		next.sync = {cur.sync[1:0], companion_frame_strobe};
		if (cur.sync[1] == cur.sync[2]) begin
			next.comp_level = cur.sync[2];
		end

		// The answer is ready in the first access cycle, so a transfer never waits.
		next.pready = psel & ~penable;
		next.pslverr = 1'b0;
		if (psel & ~penable) begin
			next.prdata = 32'h0000_0000;
			unique case (paddr)
				`DHI_OFF_CTRL: next.prdata[5:0] = cur.ctrl;
				`DHI_OFF_DIV: next.prdata[7:0] = cur.half_div;
				`DHI_OFF_DATA: next.prdata[13:0] = cur.word;
				`DHI_OFF_LOAD: next.prdata = 32'h0000_0000;
				`DHI_OFF_STATUS: begin
					next.prdata[`DHI_STAT_OVERRUN] = cur.overrun;
					next.prdata[`DHI_STAT_BUSY] = (cur.state != dhi_idle);
					next.prdata[`DHI_STAT_COMPANION] = cur.comp_level;
				end
				default: next.pslverr = 1'b1;
			endcase
		end

		if (access & pwrite) begin
			unique case (paddr)
				`DHI_OFF_CTRL: begin
					if (cur.state == dhi_idle) begin
						next.ctrl = pwdata[5:0];
					end else begin
						next.overrun = 1'b1;
					end
				end
				// The data bit moves one clock after each fall, so a half period needs two clocks.
				`DHI_OFF_DIV: next.half_div = (pwdata[7:0] < 8'h02) ? 8'h02 : pwdata[7:0];
				`DHI_OFF_STATUS: begin
					if (pwdata[`DHI_STAT_OVERRUN]) begin
						next.overrun = 1'b0;
					end
				end
				`DHI_OFF_DATA: begin
					if (cur.state != dhi_idle) begin
						next.overrun = 1'b1;
					end else begin
						next.word = pwdata[13:0];
						if (cur.ctrl[`DHI_CTRL_SERIAL]) begin
							next.state = dhi_gate;
						end else begin
							// [RL17] Bus word under select.
							next.cs_n = 1'b0;
							next.bus = pwdata[13:0];
							next.cnt = 4'(SETUP_CYCLES);
							next.state = dhi_setup;
						end
					end
				end
				`DHI_OFF_LOAD: begin
					if (cur.state != dhi_idle) begin
						next.overrun = 1'b1;
					end else if (!cur.ctrl[`DHI_CTRL_HELD_LOW]) begin
						// [RL1] Load at its own address.
						load_go = 1'b1;
						next.state = dhi_load;
					end
				end
				default: begin
				end
			endcase
		end

		unique case (cur.state)
			dhi_idle: begin
			end
			dhi_setup: begin
				if (cur.cnt != 4'h0) begin
					next.cnt = cur.cnt - 4'h1;
				end else begin
					wr_go = 1'b1;
					next.state = dhi_strobe;
				end
			end
			dhi_strobe: begin
				if (wr_done) begin
					next.state = dhi_hold;
				end
			end
			dhi_hold: begin
				// [RL2] Select ends before load.
				next.cs_n = 1'b1;
				next.bus = 14'h0000;
				if (cur.ctrl[`DHI_CTRL_LOAD_AFTER] & ~cur.ctrl[`DHI_CTRL_HELD_LOW]) begin
					// [RL18] Separate load pulse.
					load_go = 1'b1;
					next.state = dhi_load;
				end else begin
					next.state = dhi_idle;
				end
			end
			dhi_gate: begin
				// [RL13] Wait for companion strobe.
				if (~cur.ctrl[`DHI_CTRL_GATE] | ~cur.comp_level) begin
					ser_go = 1'b1;
					next.state = dhi_shift;
				end
			end
			dhi_shift: begin
				// [RL16] Load only after frame.
				if (ser_done) begin
					if (cur.ctrl[`DHI_CTRL_LOAD_AFTER] & ~cur.ctrl[`DHI_CTRL_HELD_LOW]) begin
						// [RL12] Same sequencer times load.
						load_go = 1'b1;
						next.state = dhi_load;
					end else begin
						next.state = dhi_idle;
					end
				end
			end
			dhi_load: begin
				if (load_done) begin
					next.state = dhi_idle;
				end
			end
		endcase

		// [RL3] Held low for parallel.
		// [RL5] Held low for serial.
		next.load_n = ~cur.ctrl[`DHI_CTRL_HELD_LOW] & load_pulse_n;
	end

	// ==========================================================
	// State register.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cur <= '{state: dhi_idle, ctrl: `DHI_CTRL_RESET, half_div: `DHI_DIV_RESET,
				word: 14'h0000, cnt: 4'h0, overrun: 1'b0, cs_n: 1'b1, bus: 14'h0000,
				load_n: 1'b1, sync: 3'h7, comp_level: 1'b1, pready: 1'b0,
				pslverr: 1'b0, prdata: 32'h0000_0000};
		end else begin
			cur <= next;
		end
	end

	// ==========================================================
	// Strobe and frame engines.
	dhi_pulse #(
		.CYCLES(WR_CYCLES)
	) u_wr_pulse (
		.clock(clock),
		.rst(rst),
		.start(wr_go),
		.pulse_n(wr_pulse_n),
		.done(wr_done)
	);

	dhi_pulse #(
		.CYCLES(LOAD_CYCLES)
	) u_load_pulse (
		.clock(clock),
		.rst(rst),
		.start(load_go),
		.pulse_n(load_pulse_n),
		.done(load_done)
	);

	dhi_serial_tx u_serial (
		.clock(clock),
		.rst(rst),
		.start(ser_go),
		.frame(frame),
		.half_div(cur.half_div),
		.sclk(dac_sclk),
		.sync_n(dac_sync_n),
		.sdata(dac_sdata),
		.done(ser_done)
	);

	// ==========================================================
	// Outputs.
	assign prdata = cur.prdata;
	assign pready = cur.pready;
	assign pslverr = cur.pslverr;
	assign dac_cs_n = cur.cs_n;
	assign dac_wr_n = wr_pulse_n;
	// [RL4] Bus idle in serial mode.
	assign dac_data = cur.bus;
	assign output_load_strobe_n = cur.load_n;
	// The select pin must sit at the negative rail in serial mode; a level shifter follows this line.
	assign serial_mode_select = cur.ctrl[`DHI_CTRL_SERIAL];
	assign bit_order_select = cur.ctrl[`DHI_CTRL_ORDER];
	assign alignment_select = cur.ctrl[`DHI_CTRL_ALIGN];

endmodule // dhi_dac_host
`default_nettype wire

// *** dhi_host_monitor.sv ***
// Pin and bus checker for the converter host.
`timescale 1ns/10ps
`default_nettype none
module dhi_host_monitor (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Watched ports.
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic dac_cs_n,
	input wire logic dac_wr_n,
	input wire logic [13:0] dac_data,
	input wire logic output_load_strobe_n,
	input wire logic dac_sclk,
	input wire logic dac_sync_n,
	input wire logic dac_sdata,
	input wire logic serial_mode_select,
	input wire logic bit_order_select,
	input wire logic alignment_select
);
	// ==========
	// Falling bit clock edges within one frame.
	logic [4:0] falls;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			falls <= 5'h00;
		else if (dac_sync_n)
			falls <= 5'h00;
		else if ($fell(dac_sclk))
			falls <= falls + 5'h01;
	end
	chk_load_no_frame: assert property ($fell(output_load_strobe_n) |-> dac_sync_n && !dac_sclk)
		else $error("load strobe fell inside a frame");
	chk_load_no_select: assert property ($fell(output_load_strobe_n) |-> dac_cs_n && dac_wr_n)
		else $error("load strobe fell with select or write low");
	chk_data_steady: assert property (dac_sclk |-> $stable(dac_sdata))
		else $error("serial data moved while bit clock high");
	chk_clock_gated: assert property (dac_sclk |-> !dac_sync_n)
		else $error("bit clock ran outside a frame");
	chk_sixteen_falls: assert property ($rose(dac_sync_n) |-> falls == 5'h10)
		else $error("frame did not hold sixteen falling edges");
	chk_frame_start: assert property ($fell(dac_sync_n) |-> !dac_sclk ##1 !dac_sync_n [*4])
		else $error("frame marker or bit clock wrong at frame start");
	chk_straps_hold: assert property (!dac_sync_n |-> $stable({bit_order_select, alignment_select}))
		else $error("straps moved during a frame");
	chk_serial_idle: assert property (serial_mode_select |-> dac_cs_n && dac_data == 14'h0000)
		else $error("parallel bus active in serial mode");
	chk_apb_ready: assert property (psel && !penable |=> pready)
		else $error("no ready in the access cycle");
	chk_write_width: assert property ($fell(dac_wr_n) |-> (!dac_wr_n && !dac_cs_n) [*5] ##1 dac_wr_n)
		else $error("write strobe width or select wrong");
	cover property ($rose(dac_sync_n));
	cover property ($rose(dac_wr_n));
	cover property ($fell(output_load_strobe_n));
endmodule // dhi_host_monitor
bind dhi_dac_host dhi_host_monitor mon_u (.clock, .rst, .psel, .penable, .pready, .dac_cs_n, .dac_wr_n,
	.dac_data, .output_load_strobe_n, .dac_sclk, .dac_sync_n, .dac_sdata, .serial_mode_select,
	.bit_order_select, .alignment_select);
`default_nettype wire

// *** dhi_dev_model.sv ***
// Behavioural model of the dual-latch converter.
`timescale 1ns/10ps
`default_nettype none
module dhi_dev_model (
	// Parallel pins.
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic [13:0] data,
	input wire logic load_n,
	// Serial pins and straps.
	input wire logic sclk,
	input wire logic sync_n,
	input wire logic sdata,
	input wire logic serial_sel,
	input wire logic order,
	input wire logic align,
	// Latch contents.
	output logic [13:0] in_latch,
	output logic [13:0] dac_latch
);
	// ==========
	// Latches.
	logic [15:0] sh;
	logic [4:0] n;
	logic [13:0] w;
	initial begin
		in_latch = 14'h0000;
		dac_latch = 14'h0000;
		n = 5'h00;
	end
	always @(posedge wr_n) begin
		if (!cs_n && !serial_sel) begin
			in_latch = data;
			if (!load_n)
				dac_latch = data;
		end
	end
	always @(negedge load_n) begin
		if (sync_n)
			dac_latch = in_latch;
	end
	always @(negedge sync_n) n = 5'h00;
	always @(negedge sclk) begin
		if (serial_sel && !sync_n) begin
			sh = {sh[14:0], sdata};
			n = n + 5'h01;
			if (n == 5'h10) begin
				w = align ? sh[15:2] : sh[13:0];
				if (order)
					in_latch = w;
				else
					in_latch = {<<{w}};
				if (!load_n)
					dac_latch = in_latch;
			end
		end
	end
endmodule // dhi_dev_model
`default_nettype wire

// *** test_dhi_dac_host.sv ***
// Self-checking bench for the converter host.
`timescale 1ns/10ps
`default_nettype none
`include "dhi_map.svh"
module test_dhi_dac_host;
	// ==========
	// Signals.
	logic clock, rst, psel, penable, pwrite, pready, pslverr, er, companion_frame_strobe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic dac_cs_n, dac_wr_n, output_load_strobe_n, dac_sclk, dac_sync_n, dac_sdata;
	logic serial_mode_select, bit_order_select, alignment_select;
	logic [13:0] dac_data, in_latch, dac_latch, w;
	int miscompares, compares, i;
	dhi_dac_host dut_u (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .dac_cs_n, .dac_wr_n, .dac_data, .output_load_strobe_n, .dac_sclk, .dac_sync_n,
		.dac_sdata, .serial_mode_select, .bit_order_select, .alignment_select, .companion_frame_strobe);
	dhi_dev_model dev_u (.cs_n(dac_cs_n), .wr_n(dac_wr_n), .data(dac_data), .load_n(output_load_strobe_n),
		.sclk(dac_sclk), .sync_n(dac_sync_n), .sdata(dac_sdata), .serial_sel(serial_mode_select),
		.order(bit_order_select), .align(alignment_select), .in_latch, .dac_latch);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic timed_out;
		miscompares++;
		print_verdict;
	endtask
	// A transfer holds its request until pready is seen high at a rising edge.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int t;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (t = 0; t < 20; t++) begin
			@(posedge clock);
			if (pready === 1'b1)
				break;
		end
		if (t == 20) timed_out;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_idle;
		int t;
		for (t = 0; t < 3000; t++) begin
			apb(1'b0, `DHI_OFF_STATUS, 32'h0);
			if (rd[1] === 1'b0)
				break;
		end
		if (t == 3000) timed_out;
	endtask
	task automatic send(input logic [31:0] ctrl, input logic [13:0] word);
		apb(1'b1, `DHI_OFF_CTRL, ctrl);
		apb(1'b1, `DHI_OFF_DATA, {18'h0, word});
		wait_idle;
	endtask
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata, companion_frame_strobe} = {3'h4, 1'b0, 12'h0, 32'h0, 1'b1};
		{miscompares, compares} = 0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		apb(1'b0, `DHI_OFF_CTRL, 32'h0);
		check("ctrl", rd, 32'h0);
		apb(1'b0, `DHI_OFF_DIV, 32'h0);
		check("div", rd, 32'h9);
		check("idle pins", {dac_cs_n, dac_wr_n, output_load_strobe_n, dac_sync_n, dac_sclk}, 32'h1e);
		apb(1'b0, 12'h040, 32'h0);
		check("unmapped err", er, 32'h1);
		check("unmapped data", rd, 32'h0);
		apb(1'b1, `DHI_OFF_DIV, 32'h2);
		apb(1'b0, `DHI_OFF_DIV, 32'h0);
		check("div", rd, 32'h2);
		$display("test reset and registers done");
		send(32'h0, 14'h2a5c);
		check("input latch", in_latch, 32'h2a5c);
		check("held output", dac_latch, 32'h0);
		apb(1'b1, `DHI_OFF_LOAD, 32'h0);
		wait_idle;
		check("loaded output", dac_latch, 32'h2a5c);
		send(32'h10, 14'h1357);
		check("auto load", dac_latch, 32'h1357);
		send(32'h08, 14'h3ffe);
		check("held low load", dac_latch, 32'h3ffe);
		$display("test parallel done");
		apb(1'b1, `DHI_OFF_CTRL, 32'h0);
		apb(1'b1, `DHI_OFF_DATA, 32'h1);
		apb(1'b1, `DHI_OFF_DATA, 32'h2);
		wait_idle;
		check("overrun", rd, 32'h5);
		check("refused word", in_latch, 32'h1);
		apb(1'b1, `DHI_OFF_STATUS, 32'h1);
		apb(1'b0, `DHI_OFF_STATUS, 32'h0);
		check("overrun clear", rd, 32'h4);
		$display("test overrun done");
		for (i = 0; i < 4; i++) begin
			w = 14'h2c71 ^ 14'(i * 14'h0413);
			send(32'h9 | (i << 1), w);
			check("serial word", dac_latch, w);
			check("straps", {alignment_select, bit_order_select}, i);
			check("serial select", serial_mode_select, 32'h1);
		end
		send(32'h13, 14'h0abc);
		check("serial auto load", dac_latch, 32'h0abc);
		$display("test serial done");
		send(32'h0b, 14'h0000);
		apb(1'b1, `DHI_OFF_CTRL, 32'h2b);
		apb(1'b1, `DHI_OFF_DATA, 32'h1111);
		repeat (40) @(posedge clock);
		check("gated frame", dac_sync_n, 32'h1);
		companion_frame_strobe <= 1'b0;
		wait_idle;
		check("gated word", dac_latch, 32'h1111);
		companion_frame_strobe <= 1'b1;
		$display("test companion done");
		print_verdict;
	end
endmodule // test_dhi_dac_host
`default_nettype wire
